// ### rtl/port_irq_mask_and_op_control.v
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "port_ctrl_defs.vh"

// Function
// - One 8-bit mask register per port gates status bits onto interrupt output.
// - Mask zero passes a source, one blocks it; all reset to zero.
// - Mask bit 3 gates SGMII autoneg done; meaningful only on port 7.
// - Mask bit 1 gates the PHY interrupt; only on integrated-PHY ports.
// - Mask bit 0 gates the ACL counter interrupt on every port.
// - Control bit 7 turns egress frames around in the MAC back to fabric.
// - Control bit 6 returns line frames out the same port, bypassing fabric.
// - PHY and media-independent ports alike loop line rx to tx; HAS_PHY does not change the path.
// - Control bit 2 makes this the host port with tail tagging enabled.
// - Two-bit split field: 00 one, 01 two, 10 four queues, 11 reserved.
// - With two or four queues frames go by priority; one queue ignores it.
// - ACL status clears when its mask bit is written one then zero.
module port_irq_mask_and_op_control #(
  parameter PORT_NUM = 7,
  parameter HAS_PHY = 0,
  parameter DW = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Register port
  input wire [11:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  // Interrupt events, one-cycle pulses
  input wire acl_event,
  input wire phy_event,
  input wire sgmii_an_event,
  output wire irq,
  // Fabric side of the MAC
  input wire [DW-1:0] fab_tx_data,
  input wire fab_tx_valid,
  input wire [2:0] fab_tx_prio,
  output reg [DW-1:0] fab_rx_data,
  output reg fab_rx_valid,
  // Line side of the MAC
  input wire [DW-1:0] line_rx_data,
  input wire line_rx_valid,
  output reg [DW-1:0] line_tx_data,
  output reg line_tx_valid,
  // Incoming fabric-bound path from the line
  output reg [DW-1:0] ing_data,
  output reg ing_valid,
  // Queue manager
  output reg [1:0] queue_sel,
  output wire [1:0] queue_count_code,
  output wire prio_enable,
  output wire tail_tag_en
);

  // ************************************************************
  // Registers
  // ************************************************************
  reg [7:0] mask_reg;
  reg [7:0] mask_next;
  reg [7:0] op_reg;
  reg [7:0] op_next;
  reg acl_mask_armed_reg;
  reg acl_mask_armed_next;
  reg [7:0] rdata_next;
  reg [DW-1:0] fab_rx_data_next;
  reg fab_rx_valid_next;
  reg [DW-1:0] line_tx_data_next;
  reg line_tx_valid_next;
  reg [DW-1:0] ing_data_next;
  reg ing_valid_next;
  reg [1:0] queue_sel_next;
  wire [7:0] status_bits;
  wire [7:0] src_event;
  wire [7:0] src_clear;
  wire [7:0] src_valid;
  wire [7:0] wmask;
  wire [1:0] split_code;
  wire wr_mask;
  wire wr_op;
  wire acl_clear;
  wire local_lb;
  wire remote_lb;
  genvar gi;

  // ************************************************************
  // Write decode and source map
  // ************************************************************
  assign wr_mask = wr_stb && (addr == `OFF_IRQ_MASK);
  assign wr_op = wr_stb && (addr == `OFF_OP_CTRL);

  // Bits that exist on this port instance
  assign src_valid = {
    4'h0,
    (PORT_NUM == 7) ? 1'b1 : 1'b0,
    1'b0,
    (HAS_PHY != 0) ? 1'b1 : 1'b0,
    1'b1
  };
  assign wmask = `MASK_IRQ_VALID;

  // Reserved positions carry no event, so their flags stay at zero
  assign src_event = {
    4'h0,
    sgmii_an_event,
    1'b0,
    phy_event,
    acl_event
  };

  // ************************************************************
  // Register writes
  // ************************************************************
  // Reserved bits are dropped on the way in, so they read back as zero
  always @* begin
    mask_next = mask_reg;
    op_next = op_reg;
    if (wr_mask) begin
      mask_next = wdata & wmask;
    end
    if (wr_op) begin
      op_next = wdata & `MASK_OP_VALID;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= `RST_IRQ_MASK;
      op_reg <= `RST_OP_CTRL;
    end else begin
      mask_reg <= mask_next;
      op_reg <= op_next;
    end
  end

  // ************************************************************
  // ACL clear arming
  // ************************************************************
  // A clear needs the mask bit written to one first, then back to zero
  always @* begin
    acl_mask_armed_next = acl_mask_armed_reg;
    if (wr_mask) begin
      acl_mask_armed_next = wdata[`BIT_ACL];
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acl_mask_armed_reg <= `RST_ACL_ARMED;
    end else begin
      acl_mask_armed_reg <= acl_mask_armed_next;
    end
  end

  assign acl_clear = wr_mask && !wdata[`BIT_ACL] && acl_mask_armed_reg;
  assign src_clear = {7'h00, acl_clear};

  // ************************************************************
  // Interrupt status
  // ************************************************************
  // One sticky flag per source; an event wins over a clear in the same cycle
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_status
      reg flag_reg;
      reg flag_next;

      always @* begin
        flag_next = flag_reg;
        if (src_clear[gi]) begin
          flag_next = 1'b0;
        end
        if (src_event[gi] && src_valid[gi]) begin
          flag_next = 1'b1;
        end
      end

      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          flag_reg <= `RST_STATUS_BIT;
        end else begin
          flag_reg <= flag_next;
        end
      end
      assign status_bits[gi] = flag_reg;
    end
  endgenerate

  // ************************************************************
  // Interrupt output
  // ************************************************************
  // PHY and SGMII status are sticky until reset; only the ACL flag has a clear
  assign irq = |(status_bits & ~mask_reg & src_valid);

  // ************************************************************
  // Read port
  // ************************************************************
  always @* begin
    rdata_next = 8'h00;
    if (rd_stb) begin
      case (addr)
        `OFF_IRQ_MASK: begin
          rdata_next = mask_reg;
        end
        `OFF_OP_CTRL: begin
          rdata_next = op_reg;
        end
        `OFF_IRQ_STATUS: begin
          rdata_next = status_bits;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // Read data stand for one cycle only, then fall back to zero
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= `RST_RDATA;
    end else begin
      rdata <= rdata_next;
    end
  end

  // ************************************************************
  // Loopback steering
  // ************************************************************
  assign local_lb = op_reg[`BIT_LOCAL_LB];
  assign remote_lb = op_reg[`BIT_REMOTE_LB];

  // Remote loopback wins the line transmitter when both modes are set
  always @* begin
    fab_rx_data_next = fab_tx_data;
    fab_rx_valid_next = fab_tx_valid && local_lb;
    ing_data_next = line_rx_data;
    ing_valid_next = line_rx_valid && !remote_lb;
    if (remote_lb) begin
      line_tx_data_next = line_rx_data;
      line_tx_valid_next = line_rx_valid;
    end else begin
      line_tx_data_next = fab_tx_data;
      line_tx_valid_next = fab_tx_valid && !local_lb;
    end
  end

  // ************************************************************
  // Datapath output stage
  // ************************************************************
  // Single register stage only: no elastic buffer, rates must match
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fab_rx_data <= {DW{1'b0}};
      fab_rx_valid <= 1'b0;
      line_tx_data <= {DW{1'b0}};
      line_tx_valid <= 1'b0;
      ing_data <= {DW{1'b0}};
      ing_valid <= 1'b0;
    end else begin
      fab_rx_data <= fab_rx_data_next;
      fab_rx_valid <= fab_rx_valid_next;
      line_tx_data <= line_tx_data_next;
      line_tx_valid <= line_tx_valid_next;
      ing_data <= ing_data_next;
      ing_valid <= ing_valid_next;
    end
  end

  // ************************************************************
  // Tail tag and queue split
  // ************************************************************
  assign split_code = op_reg[1:0];
  assign tail_tag_en = op_reg[`BIT_TAIL_TAG];
  assign queue_count_code = split_code;
  assign prio_enable = (split_code == `SPLIT_TWO) || (split_code == `SPLIT_FOUR);

  // ************************************************************
  // Queue selection
  // ************************************************************
  // Reserved code 11 falls back to one queue rather than guessing a split
  always @* begin
    case (split_code)
      `SPLIT_TWO: begin
        queue_sel_next = {1'b0, fab_tx_prio[2]};
      end
      `SPLIT_FOUR: begin
        queue_sel_next = fab_tx_prio[2:1];
      end
      default: begin
        queue_sel_next = 2'h0;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      queue_sel <= `RST_QUEUE_SEL;
    end else begin
      queue_sel <= queue_sel_next;
    end
  end

endmodule // port_irq_mask_and_op_control

// ### pkg/port_ctrl_defs.vh
`ifndef PORT_CTRL_DEFS_VH
`define PORT_CTRL_DEFS_VH
// ************************************************************
// Register offsets
// ************************************************************
`define OFF_IRQ_MASK 12'h01f
`define OFF_OP_CTRL 12'h020
`define OFF_IRQ_STATUS 12'h01b
// ************************************************************
// Field positions
// ************************************************************
`define BIT_ACL 0
`define BIT_PHY 1
`define BIT_SGMII 3
`define BIT_TAIL_TAG 2
`define BIT_REMOTE_LB 6
`define BIT_LOCAL_LB 7
`define MASK_IRQ_VALID 8'h0b
`define MASK_OP_VALID 8'hc7
// ************************************************************
// Reset values
// ************************************************************
`define RST_IRQ_MASK 8'h00
`define RST_OP_CTRL 8'h00
`define RST_STATUS_BIT 1'b0
`define RST_ACL_ARMED 1'b0
`define RST_RDATA 8'h00
`define RST_QUEUE_SEL 2'h0
// ************************************************************
// Queue split encodings
// ************************************************************
`define SPLIT_ONE 2'h0
`define SPLIT_TWO 2'h1
`define SPLIT_FOUR 2'h2
`endif

// ### tb/port_ctrl_monitor.sv
`timescale 1ns/1ps
// ****
// Port control checker
// ****
module port_ctrl_monitor #(parameter DW = 8) (
  // Clock, reset, registers, interrupt
  input wire ref_clk, input wire rstn, input wire [11:0] addr, input wire [7:0] wdata,
  input wire wr_stb, input wire rd_stb, input wire [7:0] rdata, input wire acl_event, input wire irq,
  // Loopback paths and queue manager
  input wire [DW-1:0] fab_tx_data, input wire fab_tx_valid, input wire [DW-1:0] fab_rx_data,
  input wire fab_rx_valid, input wire [DW-1:0] line_rx_data, input wire line_rx_valid,
  input wire [DW-1:0] line_tx_data, input wire line_tx_valid, input wire ing_valid,
  input wire [1:0] queue_count_code, input wire prio_enable, input wire tail_tag_en
);
  // Shadows rebuilt from writes, so no internal probe is needed
  reg [7:0] m_reg;
  reg [7:0] o_reg;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      m_reg <= 8'h00;
      o_reg <= 8'h00;
    end else if (wr_stb) begin
      if (addr == 12'h01f) m_reg <= wdata;
      if (addr == 12'h020) o_reg <= wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  rd_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00) else $error("rdata idle");
  mask_read_a: assert property (rd_stb && addr == 12'h01f |=> rdata == (m_reg & 8'h0b))
    else $error("mask read");
  irq_block_a: assert property (m_reg[0] && m_reg[1] && m_reg[3] |-> !irq) else $error("irq");
  acl_irq_a: assert property (acl_event && !m_reg[0] && !wr_stb |=> irq) else $error("acl");
  local_lb_a: assert property (fab_tx_valid && o_reg[7] |=> fab_rx_valid && fab_rx_data == $past(fab_tx_data))
    else $error("local loop");
  remote_lb_a: assert property (line_rx_valid && o_reg[6] |=> line_tx_valid && !ing_valid
    && line_tx_data == $past(line_rx_data)) else $error("remote loop");
  split_code_a: assert property (queue_count_code == o_reg[1:0] && prio_enable == ^o_reg[1:0])
    else $error("split");
  tail_tag_a: assert property (tail_tag_en == o_reg[2]) else $error("tail tag");
endmodule // port_ctrl_monitor

// ### tb/tb.sv
`timescale 1ns/1ps
// ****
// Port control testbench
// ****
module tb;
  logic ref_clk = 0, rstn = 0, wr_stb = 0, rd_stb = 0, fab_tx_valid = 0, line_rx_valid = 0;
  logic acl_event = 0, phy_event = 0, sgmii_an_event = 0;
  logic [11:0] addr = 0;
  logic [7:0] wdata = 0, fab_tx_data = 0, line_rx_data = 0;
  logic [2:0] fab_tx_prio = 0;
  wire [7:0] rdata, fab_rx_data, line_tx_data, ing_data;
  wire irq, fab_rx_valid, line_tx_valid, ing_valid, prio_enable, tail_tag_en;
  wire [1:0] queue_sel, queue_count_code;
  int bad_count = 0, check_count = 0;
  port_irq_mask_and_op_control i_dut (.ref_clk, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .acl_event,
    .phy_event, .sgmii_an_event, .irq, .fab_tx_data, .fab_tx_valid, .fab_tx_prio, .fab_rx_data, .fab_rx_valid,
    .line_rx_data, .line_rx_valid, .line_tx_data, .line_tx_valid, .ing_data, .ing_valid, .queue_sel,
    .queue_count_code, .prio_enable, .tail_tag_en);
  initial forever #20 ref_clk = ~ref_clk;
  initial begin
    #80000;
    bad_count++;
    give_verdict;
  end
  task give_verdict;
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Each access waits an edge first, so a strobe is never set and cleared in one step
  task wr(input [11:0] a, input [7:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task rd(input [11:0] a, input [7:0] e);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task pulse(input [2:0] v);
    @(posedge ref_clk);
    {sgmii_an_event, phy_event, acl_event} <= v;
    @(posedge ref_clk);
    {sgmii_an_event, phy_event, acl_event} <= 3'h0;
    #1;
  endtask
  task beat(input [2:0] p);
    @(posedge ref_clk);
    {fab_tx_valid, line_rx_valid, fab_tx_data, line_rx_data, fab_tx_prio} <= {2'h3, 16'h5aa5, p};
    @(posedge ref_clk);
    {fab_tx_valid, line_rx_valid} <= 2'h0;
    #1;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(12'h01f, 8'h00);
    rd(12'h020, 8'h00);
    wr(12'h01f, 8'hff);
    rd(12'h01f, 8'h0b);
    rd(12'h055, 8'h00);
    pulse(3'h3);
    chk(irq, 0);
    rd(12'h01b, 8'h01);
    wr(12'h01f, 8'h00);
    rd(12'h01b, 8'h00);
    pulse(3'h1);
    chk(irq, 1);
    wr(12'h01f, 8'h01);
    chk(irq, 0);
    pulse(3'h2);
    wr(12'h01f, 8'h08);
    chk(irq, 0);
    pulse(3'h4);
    chk(irq, 0);
    wr(12'h01f, 8'h00);
    chk(irq, 1);
    wr(12'h020, 8'hff);
    rd(12'h020, 8'hc7);
    wr(12'h020, 8'hc0);
    beat(3'h7);
    chk({fab_rx_valid, fab_rx_data}, 9'h15a);
    chk({ing_valid, line_tx_data}, 9'h0a5);
    wr(12'h020, 8'h80);
    beat(3'h7);
    chk({line_tx_valid, fab_rx_valid, ing_valid}, 3'h3);
    for (int i = 0; i < 3; i++) begin
      wr(12'h020, 8'(4 + i));
      beat(3'h6);
      chk(queue_sel, 8'((1 << i) - 1));
      chk({tail_tag_en, prio_enable, queue_count_code}, 8'(8 + (i != 0) * 4 + i));
      chk({fab_rx_valid, line_tx_valid, line_tx_data}, 10'h15a);
      chk({ing_valid, ing_data}, 9'h1a5);
    end
    wr(12'h020, 8'h00);
    chk(tail_tag_en, 0);
    give_verdict;
  end
endmodule // tb
bind port_irq_mask_and_op_control port_ctrl_monitor #(.DW(DW)) i_mon (.ref_clk, .rstn, .addr, .wdata, .wr_stb,
  .rd_stb, .rdata, .acl_event, .irq, .fab_tx_data, .fab_tx_valid, .fab_rx_data, .fab_rx_valid, .line_rx_data,
  .line_rx_valid, .line_tx_data, .line_tx_valid, .ing_valid, .queue_count_code, .prio_enable, .tail_tag_en);
